// ===== shared/xls_pkg.sv
// constants, types and timing figures of the line sensor readout block
package xls_pkg;
    // system clock
    localparam int SYS_CLK_HZ = 10000000;
    // video sample width
    localparam int SAMPLE_W = 12;
    // elements per scan (coarse pitch default, fine pitch is 256)
    localparam int ELEM_COARSE = 128;
    localparam int ELEM_FINE = 256;
    // scan timing in half sensor clocks; scan start edge counts as clock 1
    localparam int HALF_W = 16;
    localparam logic [HALF_W-1:0] H_START = 16'h0002;
    // first video at 18.5 clocks
    localparam logic [HALF_W-1:0] H_VIDEO_FIRST = 16'h0025;
    // element spacing of four clocks, in half clocks
    localparam logic [HALF_W-1:0] H_ELEM = 16'h0008;
    // strobe rises one clock after the video (19.5), falls two clocks later
    localparam logic [2:0] PH_STROBE_RISE = 3'h2;
    localparam logic [2:0] PH_STROBE_FALL = 3'h6;
    // done pulse lasts two sensor clocks
    localparam logic [HALF_W-1:0] H_DONE_LEN = 16'h0004;
    // integration window, counted in sensor clock rising edges
    localparam logic [5:0] INT_OPEN_CLK = 6'h1e;
    localparam logic [5:0] INT_CLOSE_CLK = 6'h08;
    // buffer geometry
    localparam int FIFO_DEPTH = 16;

    // one element charge from the amplifier array
    typedef struct packed {
        logic [SAMPLE_W-1:0] value;
    } xls_sample_s;

    // readout sequencer states
    typedef enum logic [1:0] {
        XLS_IDLE = 2'b00,
        XLS_ARMED = 2'b01,
        XLS_SCAN = 2'b10,
        XLS_DONE = 2'b11
    } xls_state_e;

    // pin outputs that travel together
    typedef struct packed {
        logic [SAMPLE_W-1:0] video;
        logic video_oe_n;
        logic strobe;
        logic done_n;
    } xls_pins_s;
endpackage

// ===== src/xls_fifo.sv
// parameterised sample fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module xls_fifo
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
)
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic ready_reg, ready_next;
    logic push, pop;

    // ready is a flop so that the source sees a clean level
    always_comb
    begin
        push = i_in_valid && ready_reg;
        pop = i_out_ready && (cnt_reg != '0);
        wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next = cnt_reg;
        if (push && !pop)
        begin
            cnt_next = cnt_reg + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_next = cnt_reg - 1'b1;
        end
        ready_next = (cnt_next != DEPTH_C);
    end

    // pointer and count registers
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            ready_reg <= 1'b0;
        end
        else
        begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
            ready_reg <= ready_next;
        end
    end

    // storage array, no reset needed
    always_ff @(posedge i_sys_clk)
    begin
        if (push)
        begin
            mem[wr_reg] <= i_in_data;
        end
    end

    assign o_in_ready = ready_reg;
    assign o_out_valid = (cnt_reg != '0);
    assign o_out_data = mem[rd_reg];
endmodule
`default_nettype wire

// ===== src/xls_readout.sv
// timing generator and video readout of the line sensor
`timescale 1ns/1ps
`default_nettype none
module xls_readout
    import xls_pkg::*;
#(
    parameter int ELEMS = xls_pkg::ELEM_COARSE
)
(
    // system clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // sensor pins from the controller
    input wire logic i_sensor_clk,
    input wire logic i_reset_pulse,
    input wire logic i_chain_start_input,
    input wire logic i_chain_role_first,
    input wire logic i_gain_high,
    // charges from the amplifier array
    input wire logic i_charge_valid,
    input wire xls_pkg::xls_sample_s i_charge,
    output logic o_charge_ready,
    // sensor outputs
    output logic [xls_pkg::SAMPLE_W-1:0] o_video,
    output logic o_video_oe_n,
    output logic o_sample_strobe,
    output logic o_scan_done_pulse_n,
    output logic o_integrating,
    output logic o_high_gain
);
    import xls_pkg::*;

    localparam logic [HALF_W-1:0] H_ELEMS_END = HALF_W'(ELEMS * 8);

    // ****************************************
    // pin synchronisers and edge detection
    // ****************************************
    logic [1:0] clk_sy_reg, rst_sy_reg, chn_sy_reg, gain_sy_reg, role_sy_reg;
    logic clk_d_reg, rst_d_reg;
    logic clk_fall, clk_rise, rst_fall, rst_rise;

    // two flops on every pin; only the second stage is read by logic
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            clk_sy_reg <= 2'h0;
            rst_sy_reg <= 2'h0;
            chn_sy_reg <= 2'h0;
            gain_sy_reg <= 2'h0;
            role_sy_reg <= 2'h0;
            clk_d_reg <= 1'b0;
            rst_d_reg <= 1'b0;
        end
        else
        begin
            clk_sy_reg <= {clk_sy_reg[0], i_sensor_clk};
            rst_sy_reg <= {rst_sy_reg[0], i_reset_pulse};
            chn_sy_reg <= {chn_sy_reg[0], i_chain_start_input};
            gain_sy_reg <= {gain_sy_reg[0], i_gain_high};
            role_sy_reg <= {role_sy_reg[0], i_chain_role_first};
            clk_d_reg <= clk_sy_reg[1];
            rst_d_reg <= rst_sy_reg[1];
        end
    end

    // edges of the sensor clock and reset seen in the system domain
    always_comb
    begin
        clk_fall = clk_d_reg && !clk_sy_reg[1];
        clk_rise = !clk_d_reg && clk_sy_reg[1];
        rst_fall = rst_d_reg && !rst_sy_reg[1];
        rst_rise = !rst_d_reg && rst_sy_reg[1];
    end

    // ****************************************
    // sample buffer
    // ****************************************
    logic fifo_valid;
    logic [SAMPLE_W-1:0] fifo_data;
    logic fifo_pop;

    xls_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(i_charge_valid),
        .i_in_data(i_charge.value),
        .o_in_ready(o_charge_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(fifo_pop)
    );

    // ****************************************
    // integration window
    // ****************************************
    logic [5:0] icnt_reg, icnt_next;
    logic integ_reg, integ_next;

    // reset is aligned to a rising clock edge, so rising edges are counted
    always_comb
    begin
        icnt_next = icnt_reg;
        integ_next = integ_reg;
        if (rst_rise || rst_fall)
        begin
            icnt_next = 6'h00;
        end
        else if (clk_rise && icnt_reg != 6'h3f)
        begin
            icnt_next = icnt_reg + 1'b1;
            if (rst_sy_reg[1] && icnt_next == INT_OPEN_CLK)
            begin
                integ_next = 1'b1;
            end
            if (!rst_sy_reg[1] && icnt_next == INT_CLOSE_CLK)
            begin
                integ_next = 1'b0;
            end
        end
    end

    // window registers
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            icnt_reg <= 6'h3f;
            integ_reg <= 1'b0;
        end
        else
        begin
            icnt_reg <= icnt_next;
            integ_reg <= integ_next;
        end
    end

    // ****************************************
    // scan sequencer
    // ****************************************
    xls_state_e st_reg, st_next;
    logic [HALF_W-1:0] h_reg, h_next;
    xls_pins_s pins_reg, pins_next;
    logic gain_reg, gain_next;
    logic [HALF_W-1:0] off;
    logic start_ok;

    // true when the phase offset lands on the given phase of an element inside the scan
    function automatic logic at_phase(input logic [HALF_W-1:0] o,
                                      input logic [2:0] ph);
        at_phase = (o[2:0] == ph) && (o < H_ELEMS_END);
    endfunction

    always_comb
    begin
        st_next = st_reg;
        h_next = h_reg;
        pins_next = pins_reg;
        gain_next = gain_sy_reg[1];
        fifo_pop = 1'b0;
        off = HALF_W'(h_reg - H_VIDEO_FIRST);
        // a later chain member waits for the previous done pulse
        start_ok = role_sy_reg[1] || !chn_sy_reg[1];
        case (st_reg)
            XLS_IDLE:
            begin
                if (rst_fall)
                begin
                    st_next = XLS_ARMED;
                end
            end
            XLS_ARMED:
            begin
                if (rst_sy_reg[1])
                begin
                    st_next = XLS_IDLE;
                end
                else if (clk_fall && start_ok)
                begin
                    st_next = XLS_SCAN;
                    h_next = H_START;
                end
            end
            XLS_SCAN:
            begin
                if (clk_fall || clk_rise)
                begin
                    h_next = h_reg + 1'b1;
                    off = HALF_W'(h_next - H_VIDEO_FIRST);
                    if (h_next >= H_VIDEO_FIRST)
                    begin
                        if (at_phase(off, 3'h0))
                        begin
                            // an empty buffer holds the last word
                            pins_next.video = fifo_valid ? fifo_data
                                : pins_reg.video;
                            pins_next.video_oe_n = 1'b0;
                            fifo_pop = fifo_valid;
                        end
                        if (at_phase(off, PH_STROBE_RISE))
                        begin
                            pins_next.strobe = 1'b1;
                        end
                        if (at_phase(off, PH_STROBE_FALL))
                        begin
                            pins_next.strobe = 1'b0;
                        end
                        if (off == H_ELEMS_END)
                        begin
                            st_next = XLS_DONE;
                            h_next = '0;
                            pins_next.done_n = 1'b0;
                            pins_next.video_oe_n = 1'b1;
                        end
                    end
                end
            end
            XLS_DONE:
            begin
                if (clk_fall || clk_rise)
                begin
                    h_next = h_reg + 1'b1;
                    if (h_next == H_DONE_LEN)
                    begin
                        pins_next.done_n = 1'b1;
                        st_next = XLS_IDLE;
                    end
                end
            end
            default:
            begin
                st_next = XLS_IDLE;
            end
        endcase
        // a reset fall during the done pulse still arms the next scan
        if (st_reg == XLS_DONE && rst_fall)
        begin
            st_next = XLS_ARMED;
            pins_next.done_n = 1'b1;
        end
    end

    // sequencer registers; video idles released, done high, strobe and gain low
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            st_reg <= XLS_IDLE;
            h_reg <= '0;
            pins_reg <= '{video: '0, video_oe_n: 1'b1, strobe: 1'b0,
                          done_n: 1'b1};
            gain_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            h_reg <= h_next;
            pins_reg <= pins_next;
            gain_reg <= gain_next;
        end
    end

    // every output straight from a flop
    assign o_video = pins_reg.video;
    assign o_video_oe_n = pins_reg.video_oe_n;
    assign o_sample_strobe = pins_reg.strobe;
    assign o_scan_done_pulse_n = pins_reg.done_n;
    assign o_integrating = integ_reg;
    assign o_high_gain = gain_reg;
endmodule
`default_nettype wire

// ===== bench/xls_readout_monitor.sv
// pin timing checker of the line sensor readout
`timescale 1ns/1ps
`default_nettype none
// ****
// timing checker
// ****
module xls_readout_chk
    import xls_pkg::*;
#(
    parameter int ELEMS = 128,
    parameter int HALF = 6
)
(
    // clock, reset and pins in
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_reset_pulse,
    input wire logic i_gain_high,
    input wire logic i_chain_role_first,
    // sensor outputs
    input wire logic [xls_pkg::SAMPLE_W-1:0] o_video,
    input wire logic o_video_oe_n,
    input wire logic o_sample_strobe,
    input wire logic o_scan_done_pulse_n,
    input wire logic o_integrating,
    input wire logic o_high_gain
);
    logic strb_d;
    int gap_reg;
    int cnt_reg;
    int lo_reg;
    int win_reg;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // strobe gaps and counts; cleared by the done pulse so each scan
    // starts from a clean slate
    always_ff @(posedge i_sys_clk)
    begin
        strb_d <= o_sample_strobe;
        lo_reg <= o_scan_done_pulse_n ? 0 : lo_reg + 1;
        win_reg <= o_integrating ? win_reg + 1 : 0;
        if (i_sys_rst || !o_scan_done_pulse_n)
        begin
            gap_reg <= 0;
            cnt_reg <= 0;
        end
        else if (o_sample_strobe && !strb_d)
        begin
            gap_reg <= 1;
            cnt_reg <= cnt_reg + 1;
        end
        else if (gap_reg != 0)
            gap_reg <= gap_reg + 1;
    end
    strobe_driven_a: assert property (o_sample_strobe |-> !o_video_oe_n)
        else $error("strobe while video released");
    video_holds_a:
        assert property (o_sample_strobe && strb_d |-> $stable(o_video))
        else $error("video moved under strobe");
    released_at_done_a:
        assert property (!o_scan_done_pulse_n |-> o_video_oe_n)
        else $error("video driven during done");
    done_width_a:
        assert property ($rose(o_scan_done_pulse_n) |-> lo_reg == 4 * HALF)
        else $error("done pulse width");
    done_after_last_a:
        assert property ($fell(o_scan_done_pulse_n) |->
            cnt_reg == ELEMS && gap_reg == 6 * HALF)
        else $error("done not after last element");
    strobe_spacing_a:
        assert property ($rose(o_sample_strobe) && gap_reg != 0 |->
            gap_reg == 8 * HALF)
        else $error("strobe spacing");
    first_strobe_lag_a:
        assert property ($rose(o_sample_strobe) && gap_reg == 0 |->
            !$past(o_video_oe_n, 12) && $past(o_video_oe_n, 13))
        else $error("first strobe lag");
    scan_start_a:
        assert property ($fell(i_reset_pulse) && i_chain_role_first |->
            ##[228:248] $rose(o_sample_strobe))
        else $error("scan start");
    window_open_a:
        assert property ($rose(i_reset_pulse) |->
            ##[344:372] $rose(o_integrating))
        else $error("window open");
    window_close_a:
        assert property ($fell(i_reset_pulse) |->
            ##[84:104] $fell(o_integrating))
        else $error("window close");
    window_length_a:
        assert property ($fell(o_integrating) |-> win_reg inside {[444:468]})
        else $error("window length");
    gain_follows_a:
        assert property (o_high_gain != i_gain_high |->
            ##[1:6] o_high_gain == i_gain_high)
        else $error("gain select");
    cover property ($rose(o_sample_strobe));
    cover property ($fell(o_scan_done_pulse_n));
    cover property ($rose(o_integrating));
endmodule
bind xls_readout xls_readout_chk #(.ELEMS(ELEMS)) u_chk (.*);
`default_nettype wire

// ===== bench/xls_ctrl_model.sv
// readout controller model: sensor clock, reset pulse, video capture
`timescale 1ns/1ps
`default_nettype none
// ****
// controller model
// ****
module xls_ctrl_model
    import xls_pkg::*;
#(
    parameter int HALF = 6, // 600 ns pulse width
    parameter int HI = 60,
    parameter int LO = 90
)
(
    // clock and frame enable
    input wire logic i_sys_clk,
    input wire logic i_run,
    // device outputs
    input wire logic i_strobe,
    input wire logic [xls_pkg::SAMPLE_W-1:0] i_video,
    // pins to the device, captured samples
    output logic o_sensor_clk,
    output logic o_reset_pulse,
    output logic o_got,
    output logic [xls_pkg::SAMPLE_W-1:0] o_sample
);
    int ph;
    int clks;
    // idle pins; first frame may start at once
    initial
    begin
        ph = 0;
        clks = LO;
        o_sensor_clk = 1'b0;
        o_reset_pulse = 1'b0;
        o_got = 1'b0;
    end
    // free running clock; reset moves only with its rising edge
    always @(negedge i_sys_clk)
    begin
        ph = ph + 1;
        if (ph == HALF)
        begin
            ph = 0;
            o_sensor_clk <= !o_sensor_clk;
            clks = clks + int'(!o_sensor_clk);
            if (!o_sensor_clk && o_reset_pulse && clks >= HI)
            begin
                o_reset_pulse <= 1'b0;
                clks = 0;
            end
            // long low phase keeps the rise clear of the video
            else if (!o_sensor_clk && !o_reset_pulse && i_run && clks >= LO)
            begin
                o_reset_pulse <= 1'b1;
                clks = 0;
            end
        end
    end
    // capture on the strobe rising edge
    always @(posedge i_strobe)
    begin
        o_sample <= i_video;
        o_got <= !o_got;
    end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench of the line sensor readout
`timescale 1ns/1ps
`default_nettype none
// ****
// bench top
// ****
module testbench;
    import xls_pkg::*;
    localparam int ELEMS = 16;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic run = 1'b0;
    logic gain = 1'b0;
    logic cval = 1'b0;
    logic role = 1'b1;
    logic chn = 1'b1;
    xls_sample_s chg = '0;
    logic sclk, rpulse, got, rdy, oe_n, strb, done_n, integ, hg;
    logic [SAMPLE_W-1:0] video;
    logic [SAMPLE_W-1:0] samp;
    logic [SAMPLE_W-1:0] last;
    logic [SAMPLE_W-1:0] exp_q[$];
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    // 10 MHz system clock
    initial
    begin
        forever #50 i_sys_clk = !i_sys_clk;
    end
    xls_readout #(.ELEMS(ELEMS)) dut (
        .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_sensor_clk(sclk), .i_reset_pulse(rpulse),
        .i_chain_start_input(chn),
        .i_chain_role_first(role),
        .i_gain_high(gain), .i_charge_valid(cval), .i_charge(chg),
        .o_charge_ready(rdy), .o_video(video), .o_video_oe_n(oe_n),
        .o_sample_strobe(strb), .o_scan_done_pulse_n(done_n),
        .o_integrating(integ), .o_high_gain(hg));
    xls_ctrl_model ctrl (
        .i_sys_clk(i_sys_clk), .i_run(run), .i_strobe(strb),
        .i_video(video), .o_sensor_clk(sclk), .o_reset_pulse(rpulse),
        .o_got(got), .o_sample(samp));
    task automatic wrap_up();
        if (mismatches == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string n, input logic [15:0] e,
        input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // hold valid and data until ready was high at the taking edge
    task automatic push(input logic [SAMPLE_W-1:0] v);
        @(negedge i_sys_clk);
        cval = 1'b1;
        chg.value = v;
        while (rdy !== 1'b1)
            @(negedge i_sys_clk);
        exp_q.push_back(v);
        last = v;
        @(negedge i_sys_clk);
        cval = 1'b0;
    endtask
    task automatic wait_done();
        while (done_n !== 1'b0)
            @(negedge i_sys_clk);
        while (done_n !== 1'b1)
            @(negedge i_sys_clk);
    endtask
    // cycle ceiling against a hung scan
    always @(posedge i_sys_clk)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            mismatches++;
            wrap_up();
        end
    end
    // each capture retires the oldest expected charge; #1 lets ports settle
    always @(got)
    begin
        #1;
        if (cyc > 2)
            check("sample", exp_q.size() ? exp_q.pop_front() : 'x, samp);
    end
    initial
    begin
        void'($urandom(46));
        repeat (2) @(negedge i_sys_clk);
        i_sys_rst = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        // fill until the buffer refuses, then one full scan drains it
        gain = 1'b1;
        for (int i = 0; i < 16; i++)
            push(SAMPLE_W'($urandom()));
        check("full_ready", 16'h0000, {15'h0, rdy});
        run = 1'b1;
        wait_done();
        // short feed: last element repeats the newest word
        gain = 1'b0;
        for (int i = 0; i < ELEMS - 1; i++)
            push(SAMPLE_W'($urandom()));
        exp_q.push_back(last);
        wait_done();
        // later chain member: armed, but held while chain start is high
        role = 1'b0;
        for (int i = 0; i < ELEMS; i++)
            push(SAMPLE_W'($urandom()));
        wait (rpulse === 1'b1);
        run = 1'b0;
        wait (rpulse === 1'b0);
        repeat (1200) @(negedge i_sys_clk);
        check("chain_hold", 16'h0000, {15'h0, rdy});
        // the previous sensor's done pulse lets this one scan
        chn = 1'b0;
        wait_done();
        repeat (30) @(negedge i_sys_clk);
        check("left_over", 16'h0000, 16'(exp_q.size()));
        check("video_off", 16'h0001, {15'h0, oe_n});
        wrap_up();
    end
endmodule
`default_nettype wire
